// ===== shared/bsp_pkg.sv
// ------------------------------------------------------------
// board status and power control constants
// ------------------------------------------------------------
package bsp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EQ = 8'h04;
  localparam logic [7:0] ADDR_SPARE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EVENT = 8'h10;
  // widths
  localparam int EQ_W = 13;
  localparam int SPARE_W = 8;
  localparam int LED_W = 3;
  localparam int OBS_W = 2;
  localparam int PHY_N = 2;
  localparam int SYN_W = 15;
  localparam int EVT_W = 7;
  // control register fields
  localparam int CTRL_RX_RUN = 0;
  localparam int CTRL_TX_RUN = 1;
  localparam int CTRL_PWR_REQ = 2;
  localparam int CTRL_OBS_LO = 3;
  localparam int CTRL_LED_LO = 5;
  localparam int CTRL_W = 8;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h03;
  localparam logic [EQ_W-1:0] EQ_RST = 13'h1FFF;
  localparam logic [SPARE_W-1:0] SPARE_RST = 8'h00;
  // synchronised pin bus positions
  localparam int S_RX_IRQ = 0;
  localparam int S_TX_IRQ = 1;
  localparam int S_BRD_ALERT = 2;
  localparam int S_BRD_OK = 3;
  localparam int S_PRESENT = 4;
  localparam int S_SUP_OK = 5;
  localparam int S_READY = 6;
  localparam int S_PSPARE = 7;
  localparam int S_MZ_ALERT = 8;
  localparam int S_PHY_IRQ = 9;
  localparam int S_RX_DAT = 11;
  localparam int S_TX_DAT = 12;
  localparam int S_MDIO = 13;
  // idle pin levels held by the synchroniser under reset
  localparam logic [SYN_W-1:0] SYN_RST = 15'h7F97;
  // event bit positions
  localparam int E_RX_IRQ = 0;
  localparam int E_TX_IRQ = 1;
  localparam int E_BRD_ALERT = 2;
  localparam int E_BRD_LOST = 3;
  localparam int E_MZ_ALERT = 4;
  localparam int E_SUP_LOST = 5;
  localparam int E_PRES_CHG = 6;
  // mezzanine power sequence
  typedef enum logic [1:0] {BSP_OFF, BSP_WAIT_OK, BSP_RUN} bsp_pwr_e;
endpackage

// ===== hdl/bsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// two flop synchroniser for a bus of static pin levels
// ------------------------------------------------------------
module bsp_sync import bsp_pkg::*; #(
  parameter int W = SYN_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg; // first stage, read by second stage only

  // both stages reset to the idle pin levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= pin_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/bsp_mezz_seq.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// mezzanine power enable sequence
// ------------------------------------------------------------
module bsp_mezz_seq import bsp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic present_i,
  input wire logic sup_ok_i,
  output logic mezz_pwr_on_o,
  output logic mezz_pwr_on_n_o,
  output var bsp_pwr_e state_o
);
  bsp_pwr_e state_next; // next sequence state
  wire keep_on = req_i & present_i; // power may stay on

  // next state: off until asked and fitted, then wait for good supplies
  always_comb begin
    state_next = state_o;
    case (state_o)
      BSP_OFF: begin
        if (keep_on) state_next = BSP_WAIT_OK;
      end
      BSP_WAIT_OK: begin
        if (!keep_on) state_next = BSP_OFF;
        else if (sup_ok_i) state_next = BSP_RUN;
      end
      BSP_RUN: begin
        if (!keep_on) state_next = BSP_OFF;
        else if (!sup_ok_i) state_next = BSP_WAIT_OK;
      end
      default: state_next = BSP_OFF;
    endcase
  end

  // complementary enable pair, locked off under reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_o <= BSP_OFF;
      mezz_pwr_on_o <= 1'b0; // RQ20
      mezz_pwr_on_n_o <= 1'b1; // RQ20
    end else begin
      state_o <= state_next;
      mezz_pwr_on_o <= (state_next != BSP_OFF); // RQ19
      mezz_pwr_on_n_o <= (state_next == BSP_OFF); // RQ19
    end
  end
endmodule
`default_nettype wire

// ===== hdl/bsp_top.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1 - each optic has its own four lines
// RQ2 - optic pulls interrupt low when pending
// RQ3 - optic reset outputs active low, idle high
// RQ4 - optic resets follow control register bits
// RQ5 - management clock low, data only received
// RQ6 - observation outputs low when unassigned
// RQ7 - three indicator outputs, low by default
// RQ8 - shared converter alert input, active low
// RQ9 - board power good high when all good
// RQ10 - thirteen equalization enables, default high
// RQ11 - each equalization enable has own bit
// RQ12 - eight spare lines driven, not floating, once supplies ok
// RQ13 - spare lines high impedance until supplies ok
// RQ14 - phy outputs held low, rest received
// RQ15 - mezzanine presence line pulled low
// RQ16 - mezzanine supplies ok only when good
// RQ17 - mezzanine ready only when configured
// RQ18 - spare power signal reads high undriven
// RQ19 - drive true and complemented power enables
// RQ20 - power off: true low, complement high
// RQ21 - mezzanine alert low on supply problem
// RQ22 - all status inputs pass two flops
// RQ23 - spare lines release on first low sample
module bsp_top import bsp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // receive optic management
  input wire logic rx_optic_irq_n_i,
  output logic rx_optic_rst_n_o,
  output logic rx_optic_mgmt_clk_o,
  input wire logic rx_optic_mgmt_dat_i,
  output logic rx_optic_mgmt_dat_o,
  output logic rx_optic_mgmt_dat_oe_n_o,
  // transmit optic management
  input wire logic tx_optic_irq_n_i,
  output logic tx_optic_rst_n_o,
  output logic tx_optic_mgmt_clk_o,
  input wire logic tx_optic_mgmt_dat_i,
  output logic tx_optic_mgmt_dat_o,
  output logic tx_optic_mgmt_dat_oe_n_o,
  // front panel
  output logic [OBS_W-1:0] panel_obs_o,
  output logic [LED_W-1:0] panel_led_out_o,
  // board power
  input wire logic board_supply_alert_n_i,
  input wire logic board_power_ok_i,
  // fanout equalization
  output logic [EQ_W-1:0] fanout_eq_en_o,
  // mezzanine spare lines
  output logic [SPARE_W-1:0] mezz_spare_line_o,
  output logic [SPARE_W-1:0] mezz_spare_line_oe_n_o,
  // ethernet phys
  output logic [PHY_N*4-1:0] phy_txd_o,
  output logic [PHY_N-1:0] phy_tx_en_o,
  output logic [PHY_N-1:0] phy_tx_clk_out_o,
  output logic [PHY_N-1:0] phy_mdc_o,
  input wire logic [PHY_N-1:0] phy_mdio_i,
  output logic [PHY_N-1:0] phy_mdio_o,
  output logic [PHY_N-1:0] phy_mdio_oe_n_o,
  input wire logic [PHY_N-1:0] phy_irq_n_i,
  // mezzanine presence and power
  input wire logic mezz_present_n_i,
  input wire logic mezz_supplies_ok_i,
  input wire logic mezz_ready_i,
  input wire logic mezz_pwr_spare_i,
  output logic mezz_pwr_on_o,
  output logic mezz_pwr_on_n_o,
  input wire logic mezz_supply_alert_n_i
);
  // ------------------------------------------------------------
  // merge write bytes into a register
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = wd[b*8 +: 8];
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SYN_W-1:0] pin_raw; // raw asynchronous levels
  logic [SYN_W-1:0] syn; // levels after two flops
  logic [SYN_W-1:0] syn_prev; // one cycle older, for edge events

  // spare power line defaults high under reset, as if pulled up
  assign pin_raw = {phy_mdio_i, tx_optic_mgmt_dat_i, rx_optic_mgmt_dat_i,
                    phy_irq_n_i, mezz_supply_alert_n_i, mezz_pwr_spare_i,
                    mezz_ready_i, mezz_supplies_ok_i, mezz_present_n_i,
                    board_power_ok_i, board_supply_alert_n_i,
                    tx_optic_irq_n_i, rx_optic_irq_n_i};

  // every status pin passes two flops before use
  bsp_sync #(.W(SYN_W), .RST_VAL(SYN_RST)) u_sync ( // RQ22 RQ18
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_raw),
    .sync_o(syn)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg; // optic run, power request, panel
  logic [EQ_W-1:0] eq_reg; // equalization enables
  logic [SPARE_W-1:0] spare_reg; // spare line data
  logic [EVT_W-1:0] evt_reg; // sticky events
  logic [EVT_W-1:0] evt_set; // events seen this cycle
  logic [EVT_W-1:0] evt_next; // next sticky value
  logic [31:0] rd_mux; // read data selection
  bsp_pwr_e pwr_state; // sequence state
  logic [31:0] wr_ctrl; // merged control write
  logic [31:0] wr_eq; // merged enable write
  logic [31:0] wr_spare; // merged spare write

  wire access = psel_i & penable_i; // access phase
  wire done = access & pready_o; // transfer completes here
  wire wr_fire = done & pwrite_i; // write takes effect
  wire hit_ctrl = (paddr_i == ADDR_CTRL);
  wire hit_eq = (paddr_i == ADDR_EQ);
  wire hit_spare = (paddr_i == ADDR_SPARE);
  wire hit_status = (paddr_i == ADDR_STATUS);
  wire hit_evt = (paddr_i == ADDR_EVENT);
  wire mapped = hit_ctrl | hit_eq | hit_spare | hit_status | hit_evt;
  wire ro_write = pwrite_i & hit_status; // status is read only
  wire bad = ~mapped | ro_write; // answered with an error

  assign wr_ctrl = merge({24'h000000, ctrl_reg}, pwdata_i, pstrb_i);
  assign wr_eq = merge({19'h00000, eq_reg}, pwdata_i, pstrb_i);
  assign wr_spare = merge({24'h000000, spare_reg}, pwdata_i, pstrb_i);

  // status: synchronised levels, sequence state, spare drive
  wire [31:0] status_word = {14'h0000, ~mezz_spare_line_oe_n_o[0],
                             pwr_state, syn};

  assign rd_mux = hit_ctrl ? {24'h000000, ctrl_reg} :
                  hit_eq ? {19'h00000, eq_reg} :
                  hit_spare ? {24'h000000, spare_reg} :
                  hit_status ? status_word :
                  hit_evt ? {25'h0000000, evt_reg} : 32'h00000000;

  // one wait state so read data leaves a flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access & ~pready_o;
      prdata_o <= (access & ~pwrite_i & ~pready_o) ? rd_mux : 32'h00000000;
      pslverr_o <= access & ~pready_o & bad;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // control, enables and spare data take writes at completion
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST; // RQ3
      eq_reg <= EQ_RST; // RQ10
      spare_reg <= SPARE_RST;
    end else if (wr_fire) begin
      if (hit_ctrl) ctrl_reg <= wr_ctrl[CTRL_W-1:0]; // RQ4
      if (hit_eq) eq_reg <= wr_eq[EQ_W-1:0]; // RQ11
      if (hit_spare) spare_reg <= wr_spare[SPARE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // sticky events, write one to clear, set wins
  // ------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[E_RX_IRQ] = ~syn[S_RX_IRQ]; // RQ2
    evt_set[E_TX_IRQ] = ~syn[S_TX_IRQ]; // RQ2
    evt_set[E_BRD_ALERT] = ~syn[S_BRD_ALERT]; // RQ8
    evt_set[E_BRD_LOST] = syn_prev[S_BRD_OK] & ~syn[S_BRD_OK]; // RQ9
    evt_set[E_MZ_ALERT] = ~syn[S_MZ_ALERT]; // RQ21
    evt_set[E_SUP_LOST] = syn_prev[S_SUP_OK] & ~syn[S_SUP_OK]; // RQ16
    evt_set[E_PRES_CHG] = syn_prev[S_PRESENT] ^ syn[S_PRESENT]; // RQ15
  end

  wire [EVT_W-1:0] evt_clr = (wr_fire & hit_evt & pstrb_i[0]) ?
                             pwdata_i[EVT_W-1:0] : '0;
  assign evt_next = (evt_reg & ~evt_clr) | evt_set;

  // event flags and previous levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_reg <= '0;
      syn_prev <= SYN_RST;
    end else begin
      evt_reg <= evt_next;
      syn_prev <= syn;
    end
  end

  // ------------------------------------------------------------
  // mezzanine power sequence
  // ------------------------------------------------------------
  bsp_mezz_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(ctrl_reg[CTRL_PWR_REQ]),
    .present_i(~syn[S_PRESENT]),
    .sup_ok_i(syn[S_SUP_OK]),
    .mezz_pwr_on_o(mezz_pwr_on_o),
    .mezz_pwr_on_n_o(mezz_pwr_on_n_o),
    .state_o(pwr_state)
  );

  // ------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------
  // spare lines float until supplies ok is seen high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mezz_spare_line_oe_n_o <= '1; // RQ13
      mezz_spare_line_o <= '0;
    end else begin
      mezz_spare_line_oe_n_o <= {SPARE_W{~syn[S_SUP_OK]}}; // RQ13 RQ23 RQ12
      mezz_spare_line_o <= spare_reg; // RQ12
    end
  end

  // separate optic groups, panel and enables straight from registers
  assign rx_optic_rst_n_o = ctrl_reg[CTRL_RX_RUN]; // RQ1 RQ3
  assign tx_optic_rst_n_o = ctrl_reg[CTRL_TX_RUN]; // RQ1 RQ3
  assign panel_obs_o = ctrl_reg[CTRL_OBS_LO +: OBS_W]; // RQ6
  assign panel_led_out_o = ctrl_reg[CTRL_LED_LO +: LED_W]; // RQ7
  assign fanout_eq_en_o = eq_reg; // RQ10

  // management clocks low, data lines only received
  assign rx_optic_mgmt_clk_o = 1'b0; // RQ5
  assign tx_optic_mgmt_clk_o = 1'b0; // RQ5
  assign rx_optic_mgmt_dat_o = 1'b0;
  assign tx_optic_mgmt_dat_o = 1'b0;
  assign rx_optic_mgmt_dat_oe_n_o = 1'b1; // RQ5
  assign tx_optic_mgmt_dat_oe_n_o = 1'b1; // RQ5

  // no mac: phy outputs quiet, mdio received only
  assign phy_txd_o = '0; // RQ14
  assign phy_tx_en_o = '0; // RQ14
  assign phy_tx_clk_out_o = '0; // RQ14
  assign phy_mdc_o = '0; // RQ14
  assign phy_mdio_o = '0;
  assign phy_mdio_oe_n_o = '1; // RQ14

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_spare_hiz_low: assert property ( // RQ23
    !syn[S_SUP_OK] |=> mezz_spare_line_oe_n_o == '1)
    else $error("spare lines driven while supplies not ok");

  chk_spare_drive_ok: assert property ( // RQ12
    syn[S_SUP_OK] |=> mezz_spare_line_oe_n_o == '0)
    else $error("spare lines left floating with supplies ok");

  chk_sync_two_flops: assert property ( // RQ22
    $stable(pin_raw) [*3] ##0 !$past(rst_i, 2) |-> syn == pin_raw)
    else $error("synchroniser does not settle in two cycles");

  chk_pwr_pair_opposite: assert property ( // RQ19
    mezz_pwr_on_o != mezz_pwr_on_n_o)
    else $error("power enable pair not complementary");

  chk_pwr_off_absent: assert property ( // RQ20
    (syn[S_PRESENT] || !ctrl_reg[CTRL_PWR_REQ]) |=>
    !mezz_pwr_on_o && mezz_pwr_on_n_o)
    else $error("power enabled without request or mezzanine");

  chk_optic_rst_write: assert property ( // RQ4
    wr_fire && hit_ctrl && pstrb_i[0] |=>
    rx_optic_rst_n_o == $past(pwdata_i[CTRL_RX_RUN]) &&
    tx_optic_rst_n_o == $past(pwdata_i[CTRL_TX_RUN]))
    else $error("optic reset does not follow control write");

  chk_eq_write: assert property ( // RQ11
    wr_fire && hit_eq && pstrb_i == 4'hF |=>
    fanout_eq_en_o == $past(pwdata_i[EQ_W-1:0]))
    else $error("equalization enables do not follow write");

  chk_eq_hold: assert property ( // RQ10
    !(wr_fire && hit_eq) |=> $stable(fanout_eq_en_o))
    else $error("equalization enables changed without write");

  chk_quiet_outputs: assert property ( // RQ5
    !rx_optic_mgmt_clk_o && !tx_optic_mgmt_clk_o && phy_mdc_o == '0 &&
    phy_tx_clk_out_o == '0 && phy_txd_o == '0)
    else $error("quiet output driven high");

  chk_apb_answer: assert property (
    access && !pready_o |=> pready_o)
    else $error("apb answer missing after one wait");
endmodule
`default_nettype wire

// ===== tb/bsp_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// far side: optics, board supplies and mezzanine
// ------------------------------------------------------------
module bsp_far_model (
  input wire logic clk_i,
  input wire logic fitted_i,
  input wire logic sup_fault_i,
  input wire logic brd_fault_i,
  input wire logic [1:0] optic_irq_i,
  input wire logic [1:0] optic_rst_n_i,
  input wire logic pwr_on_i,
  input wire logic pwr_on_n_i,
  output logic rx_irq_n_o,
  output logic tx_irq_n_o,
  output logic brd_alert_n_o,
  output logic brd_ok_o,
  output logic present_n_o,
  output logic sup_ok_o,
  output logic ready_o,
  output logic pwr_spare_o,
  output logic alert_n_o
);
  logic [3:0] up_cnt = 4'h0; // cycles since supplies were let on
  logic sup_q = 1'b0; // last levels seen while fitted
  logic rdy_q = 1'b0;
  logic alt_q = 1'b1;
  wire logic sup_now = (up_cnt >= 4'h4);
  wire logic rdy_now = (up_cnt >= 4'h8);
  // ----------------------------------------------------------
  // supply ramp, restarted by a fault or by power removal
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (fitted_i && pwr_on_i && !pwr_on_n_i && !sup_fault_i) begin
      if (up_cnt != 4'hF) begin
        up_cnt <= up_cnt + 4'h1;
      end
    end else begin
      up_cnt <= 4'h0;
    end
    if (fitted_i) begin
      sup_q <= sup_now;
      rdy_q <= rdy_now;
      alt_q <= !sup_fault_i;
    end
  end
  // optic interrupt pulls low only while the optic runs
  assign rx_irq_n_o = !(optic_irq_i[0] && optic_rst_n_i[0]);
  assign tx_irq_n_o = !(optic_irq_i[1] && optic_rst_n_i[1]);
  assign brd_alert_n_o = !brd_fault_i;
  assign brd_ok_o = !brd_fault_i;
  // pull-down sits on the mezzanine, so absent reads high
  assign present_n_o = !fitted_i;
  // unplugged lines float: show the inverse of the last level
  assign sup_ok_o = fitted_i ? sup_now : !sup_q;
  assign ready_o = fitted_i ? rdy_now : !rdy_q;
  assign alert_n_o = fitted_i ? !sup_fault_i : !alt_q;
  assign pwr_spare_o = 1'b1;
endmodule
`default_nettype wire

// ===== tb/board_status_power_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module board_status_power_control_test import bsp_pkg::*; ;
  // ----------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------
  logic clk_i;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic pready_o, pslverr_o;
  logic [31:0] prdata_o;
  logic rx_irq_n, tx_irq_n, rx_rst_n, tx_rst_n, rx_clk, tx_clk, rx_do, tx_do, rx_oe_n, tx_oe_n;
  logic [OBS_W-1:0] obs;
  logic [LED_W-1:0] led;
  logic brd_alert_n, brd_ok, present_n, sup_ok, ready, pspare, mz_alert_n, pwr_on, pwr_on_n;
  logic [EQ_W-1:0] eq_en;
  logic [SPARE_W-1:0] spare, spare_oe_n;
  logic [PHY_N*4-1:0] txd;
  logic [PHY_N-1:0] tx_en, phy_clk, mdc, mdio_o, mdio_oe_n;
  logic fitted = 1'b1, sup_fault = 1'b0, brd_fault = 1'b0; // far side commands
  logic [1:0] irq_cmd = 2'b00;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  // open-drain data lines: pull-up unless the block drives low
  wire logic rx_dat = rx_oe_n ? 1'b1 : rx_do;
  wire logic tx_dat = tx_oe_n ? 1'b1 : tx_do;
  wire logic [1:0] mdio = ~mdio_oe_n & mdio_o | mdio_oe_n;
  bsp_top bsp_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .rx_optic_irq_n_i(rx_irq_n), .rx_optic_rst_n_o(rx_rst_n), .rx_optic_mgmt_clk_o(rx_clk),
    .rx_optic_mgmt_dat_i(rx_dat), .rx_optic_mgmt_dat_o(rx_do),
    .rx_optic_mgmt_dat_oe_n_o(rx_oe_n),
    .tx_optic_irq_n_i(tx_irq_n), .tx_optic_rst_n_o(tx_rst_n), .tx_optic_mgmt_clk_o(tx_clk),
    .tx_optic_mgmt_dat_i(tx_dat), .tx_optic_mgmt_dat_o(tx_do),
    .tx_optic_mgmt_dat_oe_n_o(tx_oe_n),
    .panel_obs_o(obs), .panel_led_out_o(led), .board_supply_alert_n_i(brd_alert_n),
    .board_power_ok_i(brd_ok), .fanout_eq_en_o(eq_en), .mezz_spare_line_o(spare),
    .mezz_spare_line_oe_n_o(spare_oe_n), .phy_txd_o(txd), .phy_tx_en_o(tx_en),
    .phy_tx_clk_out_o(phy_clk), .phy_mdc_o(mdc), .phy_mdio_i(mdio), .phy_mdio_o(mdio_o),
    .phy_mdio_oe_n_o(mdio_oe_n), .phy_irq_n_i(2'b11), .mezz_present_n_i(present_n),
    .mezz_supplies_ok_i(sup_ok), .mezz_ready_i(ready), .mezz_pwr_spare_i(pspare),
    .mezz_pwr_on_o(pwr_on), .mezz_pwr_on_n_o(pwr_on_n), .mezz_supply_alert_n_i(mz_alert_n)
  );
  bsp_far_model bsp_far_model_i (
    .clk_i(clk_i), .fitted_i(fitted), .sup_fault_i(sup_fault), .brd_fault_i(brd_fault),
    .optic_irq_i(irq_cmd), .optic_rst_n_i({tx_rst_n, rx_rst_n}), .pwr_on_i(pwr_on),
    .pwr_on_n_i(pwr_on_n), .rx_irq_n_o(rx_irq_n), .tx_irq_n_o(tx_irq_n),
    .brd_alert_n_o(brd_alert_n), .brd_ok_o(brd_ok), .present_n_o(present_n),
    .sup_ok_o(sup_ok), .ready_o(ready), .pwr_spare_o(pspare), .alert_n_o(mz_alert_n)
  );
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= 4'hF;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) check(32'h0, 32'h1, "apb answer");
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
    apb(1'b0, a, 32'h0);
    check(rd & m, e, what);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end
  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial begin
    settle(8);
    check(32'({rx_rst_n, tx_rst_n}), 32'h3, "optic reset idle");
    check(32'({rx_clk, tx_clk, rx_oe_n, tx_oe_n}), 32'h3, "optic mgmt idle");
    check(32'(obs), 32'h0, "obs idle");
    check(32'(led), 32'h0, "led idle");
    check(32'(eq_en), 32'h1FFF, "eq default");
    check(32'(spare_oe_n), 32'hFF, "spare released");
    check(32'({pwr_on, pwr_on_n}), 32'h1, "power held off");
    check(32'({txd, tx_en, phy_clk, mdc}), 32'h0, "phy outputs low");
    check(32'(mdio_oe_n), 32'h3, "mdio received");
    rst_i <= 1'b0;
    settle(1);
    done("reset");
    rdchk(ADDR_CTRL, 32'hFF, 32'h03, "ctrl reset");
    rdchk(ADDR_EQ, 32'h1FFF, 32'h1FFF, "eq reset");
    rdchk(ADDR_SPARE, 32'hFF, 32'h00, "spare reset");
    apb(1'b0, 8'h14, 32'h0);
    check(32'(er), 32'h1, "unmapped read");
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    check(32'(er), 32'h1, "status write");
    apb(1'b1, ADDR_CTRL, 32'hA8);
    check(32'({rx_rst_n, tx_rst_n}), 32'h0, "optics in reset");
    check(32'(obs), 32'h1, "obs driven");
    check(32'(led), 32'h5, "led driven");
    apb(1'b1, ADDR_CTRL, 32'h01);
    check(32'({rx_rst_n, tx_rst_n}), 32'h2, "separate optic resets");
    apb(1'b1, ADDR_CTRL, 32'h03);
    for (int i = 0; i < EQ_W; i++) begin
      apb(1'b1, ADDR_EQ, 32'h1 << i);
      check(32'(eq_en), 32'h1 << i, "eq single bit");
    end
    apb(1'b1, ADDR_EQ, 32'h1FFF);
    done("registers");
    irq_cmd <= 2'b11;
    settle(4);
    rdchk(ADDR_STATUS, 32'h3, 32'h0, "optic irq level");
    rdchk(ADDR_EVENT, 32'h3, 32'h3, "optic irq event");
    irq_cmd <= 2'b00;
    brd_fault <= 1'b1;
    settle(4);
    rdchk(ADDR_STATUS, 32'hC, 32'h0, "board fault level");
    rdchk(ADDR_EVENT, 32'hC, 32'hC, "board fault event");
    brd_fault <= 1'b0;
    settle(4);
    apb(1'b1, ADDR_EVENT, 32'h7F);
    rdchk(ADDR_EVENT, 32'h7F, 32'h0, "events cleared");
    done("status");
    apb(1'b1, ADDR_SPARE, 32'hA5);
    check(32'(spare_oe_n), 32'hFF, "spare off without power");
    apb(1'b1, ADDR_CTRL, 32'h07);
    settle(1);
    check(32'({pwr_on, pwr_on_n}), 32'h2, "power enabled");
    settle(16);
    check(32'(spare_oe_n), 32'h00, "spare driven");
    check(32'(spare), 32'hA5, "spare data");
    rdchk(ADDR_STATUS, 32'h380E0, 32'h300E0, "run state");
    sup_fault <= 1'b1;
    settle(4);
    check(32'(spare_oe_n), 32'h00, "spare held through sync");
    settle(1);
    check(32'(spare_oe_n), 32'hFF, "spare released on loss");
    rdchk(ADDR_EVENT, 32'h30, 32'h30, "mezz loss events");
    apb(1'b1, ADDR_CTRL, 32'h03);
    settle(1);
    check(32'({pwr_on, pwr_on_n}), 32'h1, "power removed");
    sup_fault <= 1'b0;
    fitted <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h07);
    settle(6);
    check(32'({pwr_on, pwr_on_n}), 32'h1, "no power when absent");
    apb(1'b1, ADDR_CTRL, 32'h03);
    fitted <= 1'b1;
    settle(6);
    rdchk(ADDR_STATUS, 32'h90, 32'h80, "present and spare high");
    rdchk(ADDR_EVENT, 32'h40, 32'h40, "presence change event");
    done("mezzanine");
    results();
  end
endmodule
`default_nettype wire
